//--- trcs_checker.sv
`timescale 1ns/10ps
module trcs_checker (
	// clock and reset
	input wire logic       clock_i,
	input wire logic       rst_n_i,
	// requesters
	input wire logic       cpu_req_i,
	input wire logic       cpu_rom_i,
	input wire logic       cpu_ack_o,
	input wire logic       io_req_i,
	input wire logic       io_ack_o,
	// readout
	input wire logic       vid_valid_o,
	input wire logic [6:0] vid_col_o,
	input wire logic       field_start_o,
	input wire logic       refresh_o
);
	logic [3:0] ph_r, ph_nxt, ln_r, ln_nxt, rf_r, rf_nxt, cp_r, cp_nxt;
	logic [5:0] cy_r, cy_nxt;
	logic [4:0] rw_r, rw_nxt;
	logic [7:0] vc_r, vc_nxt, wt_r, wt_nxt;
	logic       ak_r, eoc, eol, eor, lns;

	////////////////////////////////////////////////////////////////
	// shadow timebase, per-line counts, per-row video count and cpu wait count
	always_comb begin
		eoc    = ph_r == trcs_pkg::PHASE_LAST;
		eol    = eoc && cy_r == trcs_pkg::CYC_LAST;
		eor    = eol && ln_r == trcs_pkg::LINE_LAST;
		lns    = ph_r == 4'h0 && cy_r == 6'h00;
		ph_nxt = eoc ? 4'h0 : ph_r + 4'h1;
		cy_nxt = eol ? 6'h00 : cy_r + 6'(eoc);
		ln_nxt = eor ? 4'h0 : ln_r + 4'(eol);
		rw_nxt = (eor && rw_r == trcs_pkg::FIELD_ROW_LAST) ? 5'h00 : rw_r + 5'(eor);
		rf_nxt = eol ? 4'h0 : rf_r + 4'(refresh_o);
		cp_nxt = eol ? 4'h0 : cp_r + 4'(cpu_ack_o & ~ak_r);
		vc_nxt = eor ? 8'h00 : vc_r + 8'(vid_valid_o);
		wt_nxt = (cpu_req_i && !cpu_ack_o && !cpu_rom_i && cp_r < 4'h4) ? wt_r + 8'h01 : 8'h00;
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{ph_r, ln_r, rf_r, cp_r, cy_r, rw_r, vc_r, wt_r, ak_r} <= 44'h0;
		end else begin
			{ph_r, ln_r, rf_r, cp_r} <= {ph_nxt, ln_nxt, rf_nxt, cp_nxt};
			{cy_r, rw_r, vc_r, wt_r} <= {cy_nxt, rw_nxt, vc_nxt, wt_nxt};
			ak_r <= cpu_ack_o;
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	a_refresh_two: assert property (eol |-> rf_r == 4'h2)
		else $error("refresh count in line wrong");
	a_refresh_slot: assert property (refresh_o |-> cy_r == 6'h00 || cy_r == 6'h18)
		else $error("refresh outside its slot");
	a_cpu_budget: assert property (eol |-> cp_r <= 4'h4)
		else $error("cpu over line budget");
	a_cpu_served: assert property (wt_r <= 8'hAA)
		else $error("cpu request waited too long");
	a_video_early: assert property (vid_valid_o |-> ln_r <= trcs_pkg::VIDEO_LAST_LINE)
		else $error("video read after line 1");
	a_video_total: assert property (lns && ln_r == 4'h2 |-> vc_r == 8'h50)
		else $error("video count in row wrong");
	a_video_order: assert property (vid_valid_o |-> vid_col_o == vc_r[6:0])
		else $error("video column out of order");
	a_field_place: assert property (field_start_o |-> rw_r == 5'h00 && ln_r == 4'h2)
		else $error("field fetch misplaced");
	a_ack_cause: assert property ($rose(cpu_ack_o) |-> $past(cpu_req_i, 3))
		else $error("cpu ack without request");
	a_io_cause: assert property ($rose(io_ack_o) |-> $past(io_req_i, 3))
		else $error("io ack without request");
	a_ack_drop: assert property ($fell(cpu_req_i) |-> ##[1:4] !cpu_ack_o)
		else $error("cpu ack not released");
	a_ack_hold: assert property (cpu_req_i && cpu_ack_o |=> cpu_ack_o)
		else $error("cpu ack dropped early");
endmodule

bind trcs_scheduler trcs_checker u_trcs_checker (
	.clock_i,
	.rst_n_i,
	.cpu_req_i,
	.cpu_rom_i,
	.cpu_ack_o,
	.io_req_i,
	.io_ack_o,
	.vid_valid_o,
	.vid_col_o,
	.field_start_o,
	.refresh_o
);

//--- trcs_pkg.sv
package trcs_pkg;

	// clock and memory cycle timing
	localparam int unsigned CLK_PERIOD_NS   = 100;
	localparam int unsigned MEM_CYCLE_NS    = 1300;
	localparam int unsigned CLKS_PER_MEM    = (MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  PHASE_LAST      = 4'(CLKS_PER_MEM - 1);
	localparam logic [3:0]  PHASE_ISSUE     = 4'h0;
	localparam logic [3:0]  PHASE_DELIVER   = 4'h1;

	// allotment pattern of one scan line and one display row
	localparam logic [5:0]  CYC_LAST        = 6'h2F;
	localparam logic [3:0]  LINE_LAST       = 4'h9;
	localparam logic [5:0]  REFRESH_SLOT_A  = 6'h00;
	localparam logic [5:0]  REFRESH_SLOT_B  = 6'h18;
	localparam logic [5:0]  CPU_SLOT_PERIOD = 6'h0C;
	localparam logic [5:0]  CPU_SLOT_OFFSET = 6'h06;
	localparam logic [2:0]  CPU_PER_LINE    = 3'h4;
	localparam logic [6:0]  VIDEO_CYCLES    = 7'h50;
	localparam logic [3:0]  VIDEO_LAST_LINE = 4'h1;
	localparam logic [2:0]  FIELD_FETCHES   = 3'h6;
	localparam logic [3:0]  FIELD_LINE      = 4'h2;
	localparam logic [4:0]  FIELD_ROW_LAST  = 5'h19;
	localparam logic [4:0]  DISPLAY_SEGS    = 5'h19;
	localparam logic [6:0]  REFRESH_ROW_LAST = 7'h7F;

	// shared memory map
	localparam int unsigned RAM_DEPTH       = 4096;
	localparam logic [1:0]  RAM_PAGE_SEL    = 2'h1;
	localparam logic [13:0] CURSOR_ROW      = 14'h1000;
	localparam logic [13:0] CURSOR_COLUMN   = 14'h1001;
	localparam logic [13:0] KEY_INPUT_CHAR  = 14'h1002;
	localparam logic [13:0] ALARM_FUNCTION  = 14'h1003;
	localparam logic [13:0] PRIOR_CONDITION = 14'h1004;
	localparam logic [13:0] DISPLAY_TOP_ROW = 14'h1005;
	localparam logic [13:0] SERIAL_TX_FLAG  = 14'h100C;
	localparam logic [13:0] SERIAL_TX_CHAR  = 14'h100D;
	localparam logic [13:0] SERIAL_RX_CHAR  = 14'h100E;
	localparam logic [13:0] SERIAL_RX_FLAG  = 14'h100F;
	localparam logic [13:0] SERIAL_LINE_CONTROL  = 14'h102E;
	localparam logic [13:0] SERIAL_STATUS_ERRORS = 14'h102F;
	localparam logic [13:0] BRANCH_AREA_LO  = 14'h1008;
	localparam logic [13:0] BRANCH_AREA_HI  = 14'h100A;
	localparam logic [13:0] SW_AREA_LO      = 14'h1010;
	localparam logic [13:0] SW_AREA_HI      = 14'h102D;
	localparam logic [11:0] STATUS_LINE_IDX = 12'h030;
	localparam logic [11:0] PAGE1_IDX       = 12'h080;
	localparam logic [11:0] SEG_BYTES       = 12'h050;
	localparam logic [7:0]  UNMAPPED_DATA   = 8'hFF;
	localparam logic [7:0]  TOP_ROW_RESET   = 8'h01;

	typedef enum logic [2:0] {
		GNT_IDLE    = 3'b000,
		GNT_REFRESH = 3'b001,
		GNT_FIELD   = 3'b010,
		GNT_VIDEO   = 3'b011,
		GNT_CPU     = 3'b100,
		GNT_IO      = 3'b101
	} trcs_grant_t;

	// one access to the shared ram
	typedef struct packed {
		logic        en;
		logic        we;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} trcs_ram_op_t;

	// a requester's bus cycle as presented at the pins
	typedef struct packed {
		logic        we;
		logic [13:0] addr;
		logic [7:0]  wdata;
	} trcs_bus_req_t;

endpackage

//--- trcs_ram.sv
`timescale 1ns/10ps
module trcs_ram (
	// clock
	input  wire logic                  clock_i,
	// access
	input  wire trcs_pkg::trcs_ram_op_t op_i,
	output logic [7:0]                 rdata_o
);

	logic [7:0] mem [trcs_pkg::RAM_DEPTH];

	// no reset: contents are whatever software loads
	always_ff @(posedge clock_i) begin
		if (op_i.en && op_i.we) begin
			mem[op_i.addr] <= op_i.wdata;
		end
		rdata_o <= mem[op_i.addr];
	end

endmodule

//--- trcs_req_model.sv
`timescale 1ns/10ps
module trcs_req_model (
	// control
	input  wire logic                    clock_i,
	input  wire logic                    go_i,
	input  wire trcs_pkg::trcs_bus_req_t cmd_i,
	input  wire logic [3:0]              hold_i,
	// bus side
	output logic                         req_o,
	output trcs_pkg::trcs_bus_req_t      bus_o,
	input  wire logic                    ack_i,
	input  wire logic [7:0]              rdata_i,
	// results
	output logic                         busy_o,
	output logic                         done_o,
	output logic [7:0]                   rdata_o
);
	int n;

	initial begin
		{req_o, bus_o, busy_o, done_o, rdata_o} = 34'h0;
	end

	// four-phase requester, may hold its request slowly
	always begin
		@(posedge clock_i);
		if (go_i === 1'b1) begin
			#1;
			busy_o = 1'b1;
			bus_o = cmd_i;
			req_o = 1'b1;
			n = 0;
			while (ack_i !== 1'b1 && n < 7000) begin
				@(posedge clock_i);
				n++;
			end
			rdata_o = rdata_i;
			#1;
			done_o = ~bus_o.we;
			@(posedge clock_i);
			#1;
			done_o = 1'b0;
			repeat (hold_i) begin
				@(posedge clock_i);
				#1;
			end
			req_o = 1'b0;
			// released bus never keeps the last value
			bus_o = ~bus_o;
			n = 0;
			while (ack_i !== 1'b0 && n < 7000) begin
				@(posedge clock_i);
				n++;
			end
			#1;
			busy_o = 1'b0;
		end
	end
endmodule

//--- trcs_scheduler.sv
`timescale 1ns/10ps
// Notes on behaviour
// - cpu always gets four reserved slots per line, served on request.
// - ram cycles about twelve times per cpu cycle; eleven go elsewhere.
// - one memory cycle is 1.3 us, 48 cycles per scan line.
// - row period is ten equal lines; pattern repeats every row, except that row 0 adds the field fetch in line two.
// - cpu is granted at most four cycles in any scan line.
// - refresh takes exactly two cycles every scan line.
// - video reads 80 character bytes every row.
// - the 80 video reads always finish within the first two lines.
// - at least 42 cycles stay open to io in lines two to nine, 36 in line two of row 0.
// - cpu reads of program rom leave the bus free for others.
// - six extra field-start fetches once per video field.
// - cpu and io run on own clocks; requests are synchronised handshakes.
// - shared ram holds working registers and up to 2000 display bytes.
// - cursor, alarm and keyboard bytes pass through shared ram locations.
// - status line at 1030-107F, first page at 1080-17FF.
// - every location is selected by a 14-bit address.
// - top row register is read once per field in the field fetch.
module trcs_scheduler (
	// clock and reset
	input  wire logic                   clock_i,
	input  wire logic                   rst_n_i,
	// cpu side, own clock domain
	input  wire logic                   cpu_req_i,
	input  wire logic                   cpu_rom_i,
	input  wire trcs_pkg::trcs_bus_req_t cpu_bus_i,
	output logic                        cpu_ack_o,
	output logic [7:0]                  cpu_rdata_o,
	// io device side, own clock domain
	input  wire logic                   io_req_i,
	input  wire trcs_pkg::trcs_bus_req_t io_bus_i,
	output logic                        io_ack_o,
	output logic [7:0]                  io_rdata_o,
	// video readout
	output logic                        vid_valid_o,
	output logic [6:0]                  vid_col_o,
	output logic [7:0]                  vid_data_o,
	output logic                        field_start_o,
	output logic [7:0]                  cursor_row_o,
	output logic [7:0]                  cursor_column_o,
	output logic [7:0]                  prior_condition_o,
	output logic [7:0]                  display_top_row_o,
	output logic                        alarm_bit_o,
	output logic [7:0]                  status_first_o,
	// dram refresh
	output logic                        refresh_o,
	output logic [6:0]                  refresh_row_o
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic in_ram(input logic [13:0] a);
		in_ram = (a[13:12] == trcs_pkg::RAM_PAGE_SEL);
	endfunction

	function automatic logic cpu_only(input logic [13:0] a);
		cpu_only = (a >= trcs_pkg::BRANCH_AREA_LO && a <= trcs_pkg::BRANCH_AREA_HI) ||
			(a >= trcs_pkg::SW_AREA_LO && a <= trcs_pkg::SW_AREA_HI);
	endfunction

	function automatic logic [11:0] field_addr(input logic [2:0] idx);
		case (idx)
			3'h0:    field_addr = trcs_pkg::CURSOR_ROW[11:0];
			3'h1:    field_addr = trcs_pkg::CURSOR_COLUMN[11:0];
			3'h2:    field_addr = trcs_pkg::ALARM_FUNCTION[11:0];
			3'h3:    field_addr = trcs_pkg::PRIOR_CONDITION[11:0];
			3'h4:    field_addr = trcs_pkg::DISPLAY_TOP_ROW[11:0];
			default: field_addr = trcs_pkg::STATUS_LINE_IDX;
		endcase
	endfunction

	function automatic logic [4:0] wrap_seg(input logic [5:0] s);
		if (s >= {1'b0, trcs_pkg::DISPLAY_SEGS}) begin
			wrap_seg = 5'(s - {1'b0, trcs_pkg::DISPLAY_SEGS});
		end else begin
			wrap_seg = s[4:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// synchronisers for the foreign clock domains

	logic [1:0] cpu_req_sync_r;
	logic [1:0] cpu_rom_sync_r;
	logic [1:0] io_req_sync_r;
	trcs_pkg::trcs_bus_req_t cpu_bus_sync_r [2];
	trcs_pkg::trcs_bus_req_t io_bus_sync_r [2];

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cpu_req_sync_r <= 2'h0;
			cpu_rom_sync_r <= 2'h0;
			io_req_sync_r  <= 2'h0;
			cpu_bus_sync_r <= '{default: '0};
			io_bus_sync_r  <= '{default: '0};
		end else begin
			cpu_req_sync_r <= {cpu_req_sync_r[0], cpu_req_i};
			cpu_rom_sync_r <= {cpu_rom_sync_r[0], cpu_rom_i};
			io_req_sync_r  <= {io_req_sync_r[0], io_req_i};
			cpu_bus_sync_r[0] <= cpu_bus_i;
			cpu_bus_sync_r[1] <= cpu_bus_sync_r[0];
			io_bus_sync_r[0]  <= io_bus_i;
			io_bus_sync_r[1]  <= io_bus_sync_r[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state

	logic [3:0]            phase_r, phase_nxt;
	logic [5:0]            cyc_r, cyc_nxt;
	logic [3:0]            line_r, line_nxt;
	logic [4:0]            row_r, row_nxt;
	logic [2:0]            cpu_cnt_r, cpu_cnt_nxt;
	logic [6:0]            vid_cnt_r, vid_cnt_nxt;
	logic [2:0]            fld_cnt_r, fld_cnt_nxt;
	trcs_pkg::trcs_grant_t gnt_r, gnt_nxt;
	logic [6:0]            col_r, col_nxt;
	logic [2:0]            fidx_r, fidx_nxt;
	logic                  hit_r, hit_nxt;
	logic                  cpu_ack_r, cpu_ack_nxt;
	logic [7:0]            cpu_rdata_r, cpu_rdata_nxt;
	logic                  io_ack_r, io_ack_nxt;
	logic [7:0]            io_rdata_r, io_rdata_nxt;
	logic                  vid_valid_r, vid_valid_nxt;
	logic [6:0]            vid_col_r, vid_col_nxt;
	logic [7:0]            vid_data_r, vid_data_nxt;
	logic                  field_start_r, field_start_nxt;
	logic [7:0]            cur_row_r, cur_row_nxt;
	logic [7:0]            cur_col_r, cur_col_nxt;
	logic [7:0]            prior_r, prior_nxt;
	logic [7:0]            top_r, top_nxt;
	logic                  alarm_r, alarm_nxt;
	logic [7:0]            status_r, status_nxt;
	logic                  refresh_r, refresh_nxt;
	logic [6:0]            rfsh_row_r, rfsh_row_nxt;

	trcs_pkg::trcs_ram_op_t ram_op;
	logic [7:0]             ram_rdata;
	logic                   cpu_pend;
	logic                   io_pend;
	logic                   cpu_slot;
	logic                   refresh_slot;
	logic [4:0]             seg;
	logic [11:0]            vid_addr;

	trcs_ram u_ram (
		.clock_i (clock_i),
		.op_i    (ram_op),
		.rdata_o (ram_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// arbitration and sequencing

	always_comb begin
		phase_nxt       = phase_r;
		cyc_nxt         = cyc_r;
		line_nxt        = line_r;
		row_nxt         = row_r;
		cpu_cnt_nxt     = cpu_cnt_r;
		vid_cnt_nxt     = vid_cnt_r;
		fld_cnt_nxt     = fld_cnt_r;
		gnt_nxt         = gnt_r;
		col_nxt         = col_r;
		fidx_nxt        = fidx_r;
		hit_nxt         = hit_r;
		cpu_ack_nxt     = cpu_ack_r;
		cpu_rdata_nxt   = cpu_rdata_r;
		io_ack_nxt      = io_ack_r;
		io_rdata_nxt    = io_rdata_r;
		vid_valid_nxt   = 1'b0;
		vid_col_nxt     = vid_col_r;
		vid_data_nxt    = vid_data_r;
		field_start_nxt = 1'b0;
		cur_row_nxt     = cur_row_r;
		cur_col_nxt     = cur_col_r;
		prior_nxt       = prior_r;
		top_nxt         = top_r;
		alarm_nxt       = alarm_r;
		status_nxt      = status_r;
		refresh_nxt     = 1'b0;
		rfsh_row_nxt    = rfsh_row_r;
		ram_op          = '0;

		// four-phase handshakes: release ack once request drops
		cpu_pend = cpu_req_sync_r[1] && !cpu_ack_r && !cpu_rom_sync_r[1];
		io_pend  = io_req_sync_r[1] && !io_ack_r;
		if (!cpu_req_sync_r[1]) begin
			cpu_ack_nxt = 1'b0;
		end
		if (!io_req_sync_r[1]) begin
			io_ack_nxt = 1'b0;
		end

		cpu_slot     = ((cyc_r % trcs_pkg::CPU_SLOT_PERIOD) == trcs_pkg::CPU_SLOT_OFFSET);
		refresh_slot = (cyc_r == trcs_pkg::REFRESH_SLOT_A) ||
			(cyc_r == trcs_pkg::REFRESH_SLOT_B);
		seg      = wrap_seg(6'(top_r[4:0]) + 6'(row_r));
		vid_addr = 12'(trcs_pkg::STATUS_LINE_IDX + 12'(seg) * trcs_pkg::SEG_BYTES
			+ 12'(vid_cnt_r));

		// memory cycle timebase, 13 clocks per cycle
		if (phase_r == trcs_pkg::PHASE_LAST) begin
			phase_nxt = 4'h0;
			if (cyc_r == trcs_pkg::CYC_LAST) begin
				cyc_nxt     = 6'h00;
				cpu_cnt_nxt = 3'h0;
				if (line_r == trcs_pkg::LINE_LAST) begin
					line_nxt    = 4'h0;
					vid_cnt_nxt = 7'h00;
					if (row_r == trcs_pkg::FIELD_ROW_LAST) begin
						row_nxt     = 5'h00;
						fld_cnt_nxt = 3'h0;
					end else begin
						row_nxt = 5'(row_r + 5'h01);
					end
				end else begin
					line_nxt = 4'(line_r + 4'h1);
				end
			end else begin
				cyc_nxt = 6'(cyc_r + 6'h01);
			end
		end else begin
			phase_nxt = 4'(phase_r + 4'h1);
		end

		if (phase_r == trcs_pkg::PHASE_ISSUE) begin
			gnt_nxt = trcs_pkg::GNT_IDLE;
			hit_nxt = 1'b0;
			// fixed priority; cpu reserved slots keep its budget
			if (refresh_slot) begin
				gnt_nxt      = trcs_pkg::GNT_REFRESH;
				refresh_nxt  = 1'b1;
				rfsh_row_nxt = (rfsh_row_r == trcs_pkg::REFRESH_ROW_LAST) ? 7'h00 :
					7'(rfsh_row_r + 7'h01);
			end else if (row_r == 5'h00 && line_r == trcs_pkg::FIELD_LINE &&
				fld_cnt_r < trcs_pkg::FIELD_FETCHES && !cpu_slot) begin
				gnt_nxt     = trcs_pkg::GNT_FIELD;
				fidx_nxt    = fld_cnt_r;
				fld_cnt_nxt = 3'(fld_cnt_r + 3'h1);
				ram_op.en   = 1'b1;
				ram_op.addr = field_addr(fld_cnt_r);
				field_start_nxt = (fld_cnt_r == 3'h0);
			end else if (line_r <= trcs_pkg::VIDEO_LAST_LINE &&
				vid_cnt_r < trcs_pkg::VIDEO_CYCLES && !cpu_slot) begin
				gnt_nxt     = trcs_pkg::GNT_VIDEO;
				col_nxt     = vid_cnt_r;
				vid_cnt_nxt = 7'(vid_cnt_r + 7'h01);
				ram_op.en   = 1'b1;
				ram_op.addr = vid_addr;
			end else if (cpu_pend && cpu_cnt_r < trcs_pkg::CPU_PER_LINE) begin
				gnt_nxt      = trcs_pkg::GNT_CPU;
				cpu_cnt_nxt  = 3'(cpu_cnt_r + 3'h1);
				hit_nxt      = in_ram(cpu_bus_sync_r[1].addr);
				ram_op.en    = in_ram(cpu_bus_sync_r[1].addr);
				ram_op.we    = cpu_bus_sync_r[1].we;
				ram_op.addr  = cpu_bus_sync_r[1].addr[11:0];
				ram_op.wdata = cpu_bus_sync_r[1].wdata;
			end else if (io_pend) begin
				gnt_nxt      = trcs_pkg::GNT_IO;
				hit_nxt      = in_ram(io_bus_sync_r[1].addr) &&
					!cpu_only(io_bus_sync_r[1].addr);
				ram_op.en    = hit_nxt;
				ram_op.we    = io_bus_sync_r[1].we;
				ram_op.addr  = io_bus_sync_r[1].addr[11:0];
				ram_op.wdata = io_bus_sync_r[1].wdata;
			end
		end

		if (phase_r == trcs_pkg::PHASE_DELIVER) begin
			case (gnt_r)
				trcs_pkg::GNT_FIELD: begin
					case (fidx_r)
						3'h0:    cur_row_nxt = ram_rdata;
						3'h1:    cur_col_nxt = ram_rdata;
						3'h2:    alarm_nxt   = ram_rdata[7];
						3'h3:    prior_nxt   = ram_rdata;
						3'h4:    top_nxt     = ram_rdata;
						default: status_nxt  = ram_rdata;
					endcase
				end
				trcs_pkg::GNT_VIDEO: begin
					vid_valid_nxt = 1'b1;
					vid_col_nxt   = col_r;
					vid_data_nxt  = ram_rdata;
				end
				trcs_pkg::GNT_CPU: begin
					cpu_ack_nxt   = 1'b1;
					cpu_rdata_nxt = hit_r ? ram_rdata : trcs_pkg::UNMAPPED_DATA;
				end
				trcs_pkg::GNT_IO: begin
					io_ack_nxt   = 1'b1;
					io_rdata_nxt = hit_r ? ram_rdata : trcs_pkg::UNMAPPED_DATA;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_r       <= 4'h0;
			cyc_r         <= 6'h00;
			line_r        <= 4'h0;
			row_r         <= 5'h00;
			cpu_cnt_r     <= 3'h0;
			vid_cnt_r     <= 7'h00;
			fld_cnt_r     <= 3'h0;
			gnt_r         <= trcs_pkg::GNT_IDLE;
			col_r         <= 7'h00;
			fidx_r        <= 3'h0;
			hit_r         <= 1'b0;
			cpu_ack_r     <= 1'b0;
			cpu_rdata_r   <= 8'h00;
			io_ack_r      <= 1'b0;
			io_rdata_r    <= 8'h00;
			vid_valid_r   <= 1'b0;
			vid_col_r     <= 7'h00;
			vid_data_r    <= 8'h00;
			field_start_r <= 1'b0;
			cur_row_r     <= 8'h00;
			cur_col_r     <= 8'h00;
			prior_r       <= 8'h00;
			top_r         <= trcs_pkg::TOP_ROW_RESET;
			alarm_r       <= 1'b0;
			status_r      <= 8'h00;
			refresh_r     <= 1'b0;
			rfsh_row_r    <= 7'h00;
		end else begin
			phase_r       <= phase_nxt;
			cyc_r         <= cyc_nxt;
			line_r        <= line_nxt;
			row_r         <= row_nxt;
			cpu_cnt_r     <= cpu_cnt_nxt;
			vid_cnt_r     <= vid_cnt_nxt;
			fld_cnt_r     <= fld_cnt_nxt;
			gnt_r         <= gnt_nxt;
			col_r         <= col_nxt;
			fidx_r        <= fidx_nxt;
			hit_r         <= hit_nxt;
			cpu_ack_r     <= cpu_ack_nxt;
			cpu_rdata_r   <= cpu_rdata_nxt;
			io_ack_r      <= io_ack_nxt;
			io_rdata_r    <= io_rdata_nxt;
			vid_valid_r   <= vid_valid_nxt;
			vid_col_r     <= vid_col_nxt;
			vid_data_r    <= vid_data_nxt;
			field_start_r <= field_start_nxt;
			cur_row_r     <= cur_row_nxt;
			cur_col_r     <= cur_col_nxt;
			prior_r       <= prior_nxt;
			top_r         <= top_nxt;
			alarm_r       <= alarm_nxt;
			status_r      <= status_nxt;
			refresh_r     <= refresh_nxt;
			rfsh_row_r    <= rfsh_row_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign cpu_ack_o         = cpu_ack_r;
	assign cpu_rdata_o       = cpu_rdata_r;
	assign io_ack_o          = io_ack_r;
	assign io_rdata_o        = io_rdata_r;
	assign vid_valid_o       = vid_valid_r;
	assign vid_col_o         = vid_col_r;
	assign vid_data_o        = vid_data_r;
	assign field_start_o     = field_start_r;
	assign cursor_row_o      = cur_row_r;
	assign cursor_column_o   = cur_col_r;
	assign prior_condition_o = prior_r;
	assign display_top_row_o = top_r;
	assign alarm_bit_o       = alarm_r;
	assign status_first_o    = status_r;
	assign refresh_o         = refresh_r;
	assign refresh_row_o     = rfsh_row_r;

endmodule

//--- trcs_scheduler_tb.sv
`timescale 1ns/10ps
module trcs_scheduler_tb;
	logic                    clock_i = 1'b0;
	logic                    rst_n_i = 1'b0;
	logic                    cpu_rom = 1'b0;
	logic                    cpu_go = 1'b0;
	logic                    io_go = 1'b0;
	logic [3:0]              hold = 4'h0;
	trcs_pkg::trcs_bus_req_t cpu_cmd = 23'h0, io_cmd = 23'h0, cpu_bus, io_bus;
	logic                    cpu_req, io_req, cpu_ack, io_ack, vid_valid, field_start, alarm_bit;
	logic                    cpu_busy, io_busy, cpu_done, io_done;
	logic [7:0]              cpu_rd, io_rd, cpu_res, io_res, vid_data, crow, ccol, prior, top, stat;
	logic [6:0]              vid_col, rrow, rrow0;
	logic [7:0]              q_cpu[$], q_io[$], q_vid[$];
	int                      num_errors = 0, n_tests = 0;

	always #50 clock_i = ~clock_i;

	trcs_scheduler u_trcs_scheduler (.clock_i, .rst_n_i, .cpu_req_i(cpu_req), .cpu_rom_i(cpu_rom),
		.cpu_bus_i(cpu_bus), .cpu_ack_o(cpu_ack), .cpu_rdata_o(cpu_rd), .io_req_i(io_req),
		.io_bus_i(io_bus), .io_ack_o(io_ack), .io_rdata_o(io_rd), .vid_valid_o(vid_valid),
		.vid_col_o(vid_col), .vid_data_o(vid_data), .field_start_o(field_start),
		.cursor_row_o(crow), .cursor_column_o(ccol), .prior_condition_o(prior),
		.display_top_row_o(top), .alarm_bit_o(alarm_bit), .status_first_o(stat),
		.refresh_o(), .refresh_row_o(rrow));
	trcs_req_model u_trcs_req_model_cpu (.clock_i, .go_i(cpu_go), .cmd_i(cpu_cmd), .hold_i(hold),
		.req_o(cpu_req), .bus_o(cpu_bus), .ack_i(cpu_ack), .rdata_i(cpu_rd), .busy_o(cpu_busy),
		.done_o(cpu_done), .rdata_o(cpu_res));
	trcs_req_model u_trcs_req_model_io (.clock_i, .go_i(io_go), .cmd_i(io_cmd), .hold_i(hold),
		.req_o(io_req), .bus_o(io_bus), .ack_i(io_ack), .rdata_i(io_rd), .busy_o(io_busy),
		.done_o(io_done), .rdata_o(io_res));

	////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("errors %0d of %0d checks", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", nm, e, g);
			num_errors++;
		end
	endtask

	task automatic step(inout int n, input int lim);
		@(posedge clock_i);
		n++;
		if (n > lim) begin
			num_errors++;
			report_and_stop();
		end
	endtask

	task automatic idle(input bit c);
		int n;
		n = 0;
		do step(n, 6000); while ((c ? cpu_busy : io_busy) !== 1'b0);
	endtask

	// one bus cycle; a read notes its expected byte
	task automatic op(input bit c, input logic we, input logic [13:0] a, input logic [7:0] d,
		input logic [7:0] e, input bit w);
		@(posedge clock_i);
		#1;
		if (c) begin
			cpu_cmd = {we, a, d};
			cpu_go = 1'b1;
			if (!we) q_cpu.push_back(e);
		end else begin
			io_cmd = {we, a, d};
			io_go = 1'b1;
			if (!we) q_io.push_back(e);
		end
		@(posedge clock_i);
		#1;
		cpu_go = 1'b0;
		io_go = 1'b0;
		if (w) idle(c);
	endtask

	// result watcher
	always @(posedge clock_i) begin
		if (cpu_done === 1'b1) check("cpu rdata", q_cpu.pop_front(), cpu_res);
		if (io_done === 1'b1) check("io rdata", q_io.pop_front(), io_res);
		if (vid_valid === 1'b1 && q_vid.size() > 0 && (vid_col == 7'h00 || vid_col == 7'h4F))
			check("video byte", q_vid.pop_front(), vid_data);
	end

	////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0]  pr, st, d;
		logic [13:0] a;
		int          n;
		pr = 8'($urandom(18));
		st = 8'($urandom);
		repeat (20) @(posedge clock_i);
		check("top row reset", 8'h01, top);
		check("cursor reset", 8'h00, crow);
		#1;
		rst_n_i = 1'b1;
		// field fetch of row 0 line 2 must see these
		op(1, 1, trcs_pkg::CURSOR_ROW, 8'h0C, 8'h00, 1);
		op(1, 1, trcs_pkg::CURSOR_COLUMN, 8'h4F, 8'h00, 1);
		op(1, 1, trcs_pkg::ALARM_FUNCTION, 8'h80, 8'h00, 1);
		op(1, 1, trcs_pkg::PRIOR_CONDITION, pr, 8'h00, 1);
		op(1, 1, 14'h1030, st, 8'h00, 1);
		op(1, 1, trcs_pkg::DISPLAY_TOP_ROW, 8'h01, 8'h00, 1);
		op(1, 0, trcs_pkg::CURSOR_ROW, 8'h00, 8'h0C, 1);
		n = 0;
		while (field_start !== 1'b1) step(n, 2000);
		repeat (6 * 13 + 3) @(posedge clock_i);
		check("cursor row", 8'h0C, crow);
		check("cursor column", 8'h4F, ccol);
		check("alarm bit", 8'h01, 8'(alarm_bit));
		check("prior", pr, prior);
		check("top row", 8'h01, top);
		check("status byte", st, stat);
		// row 1 reads segment 2 with top row 1
		d = 8'($urandom);
		op(0, 1, 14'h10D0, d, 8'h00, 1);
		q_vid.push_back(d);
		d = 8'($urandom);
		op(0, 1, 14'h111F, d, 8'h00, 1);
		q_vid.push_back(d);
		n = 0;
		while (q_vid.size() > 0) step(n, 9000);
		op(1, 1, 14'h1010, 8'h5A, 8'h00, 1);
		op(0, 1, 14'h1010, 8'h33, 8'h00, 1);
		op(0, 0, 14'h1010, 8'h00, 8'hFF, 1);
		op(1, 0, 14'h1010, 8'h00, 8'h5A, 1);
		op(1, 0, 14'h0123, 8'h00, 8'hFF, 1);
		for (int i = 0; i < 6; i++) begin
			a = 14'h1080 + 14'($urandom_range(0, 32'h77F));
			d = 8'($urandom);
			hold = 4'($urandom);
			op(0, 1, a, d, 8'h00, 1);
			op(1, 0, a, 8'h00, d, 1);
		end
		#1;
		cpu_rom = 1'b1;
		op(1, 0, 14'h1010, 8'h00, 8'h5A, 0);
		op(0, 0, a, 8'h00, d, 1);
		rrow0 = rrow;
		repeat (48 * 13) @(posedge clock_i);
		check("refresh row", 8'(7'(rrow0 + 7'h02)), 8'(rrow));
		check("cpu ack on rom", 8'h00, 8'(cpu_ack));
		#1;
		cpu_rom = 1'b0;
		idle(1);
		report_and_stop();
	end
endmodule
